//--- hdl/relay_threshold_pwm_control.sv
/*
 Relay threshold control, pulse width output and front panel menu walker.
 Assumes keys arrive from pins, value and alarm come from logic on i_clock,
 and software programs it over APB with zero wait states.
*/
// Contract
// - both thresholds share hysteresis, delays, unit, alarm
// - inside energises in zone, outside reverses
// - thresholds accepted in either order
// - pulse mode only on open-collector output
// - duty linear with source across span
// - below low limit output stays low
// - above high limit output stays high
// - duty is high time over period
// - minimum high and low times win
// - minimums exceeding period force output low
// - alarm forces programmed fill percentage
// - quick view steps, reverts after 5 s
// - free access edits threshold from quick view
// - menu entry needs 2 s escape hold
// - password shows only edited digit
// - correct password opens menu, else error
// - enter descends submenu or starts editing
// - escape climbs one level, then measurement
// - one minute idle leaves menu unless editing
// - inside on between lower+hysteresis_width and higher-hysteresis_width
// - short excursions below delay change nothing
`timescale 1ns/1ps
module relay_threshold_pwm_control #(
   parameter int MS_CYCLES = relay_pwm_pkg::MS_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic signed [15:0] i_value,
   input wire logic i_alarm,
   input wire logic i_oc_fitted,
   input wire relay_pwm_pkg::key_t i_keys,
   output logic o_relay,
   output relay_pwm_pkg::display_menu_t o_display_menu
);
   import relay_pwm_pkg::*;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   ctrl_t ctrl_q;
   logic signed [15:0] thr1_q, thr2_q, span_lo_q, span_hi_q;
   logic [15:0] hysteresis_width_q, ton_q, turn_off_delay_q, period_q, min_hi_q, min_lo_q, pass_q;
   logic [6:0] fill_q;
   logic [31:0] rdata_d;
   logic mapped, wr_acc;
   logic relay_q, pwm_w, out_d, conflict, pulse_width_selection_ok;
   menu_t menu_q;
   logic [2:0] qv_q;
   logic [1:0] pw_pos_q;
   logic [3:0] pw_dig_q [PW_DIGITS];

   assign o_pready = 1'b1;
   assign mapped = (i_paddr[1:0] == 2'b00) && (i_paddr <= STATUS_OFS);
   assign wr_acc = i_psel && i_penable && i_pwrite && mapped;
   assign o_pslverr = i_psel && i_penable && !mapped;

   // software writes
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_q <= CTRL_RESET;
         thr1_q <= '0;
         thr2_q <= '0;
         hysteresis_width_q <= '0;
         ton_q <= '0;
         turn_off_delay_q <= '0;
         span_lo_q <= '0;
         span_hi_q <= '0;
         period_q <= PERIOD_RESET;
         min_hi_q <= '0;
         min_lo_q <= '0;
         fill_q <= '0;
         pass_q <= '0;
      end else if (wr_acc) begin
         unique case (i_paddr)
            CTRL_OFS: ctrl_q <= ctrl_t'({22'h0, i_pwdata[9:0]});
            THR_OFS: begin
               thr1_q <= i_pwdata[15:0];
               thr2_q <= i_pwdata[31:16];
            end
            HYSTERESIS_WIDTH_OFS: hysteresis_width_q <= i_pwdata[15:0];
            DELAY_OFS: begin
               ton_q <= i_pwdata[15:0];
               turn_off_delay_q <= i_pwdata[31:16];
            end
            SPAN_OFS: begin
               span_lo_q <= i_pwdata[15:0];
               span_hi_q <= i_pwdata[31:16];
            end
            PERIOD_OFS: period_q <= i_pwdata[15:0];
            MINT_OFS: begin
               min_hi_q <= i_pwdata[15:0];
               min_lo_q <= i_pwdata[31:16];
            end
            FILL_OFS: fill_q <= i_pwdata[6:0];
            PASS_OFS: pass_q <= i_pwdata[15:0];
            default: ;
         endcase
      end
   end

   // read mux, latched in the setup cycle
   always_comb begin
      unique case (i_paddr)
         CTRL_OFS: rdata_d = ctrl_q;
         THR_OFS: rdata_d = {thr2_q, thr1_q};
         HYSTERESIS_WIDTH_OFS: rdata_d = {16'h0, hysteresis_width_q};
         DELAY_OFS: rdata_d = {turn_off_delay_q, ton_q};
         SPAN_OFS: rdata_d = {span_hi_q, span_lo_q};
         PERIOD_OFS: rdata_d = {16'h0, period_q};
         MINT_OFS: rdata_d = {min_lo_q, min_hi_q};
         FILL_OFS: rdata_d = {25'h0, fill_q};
         PASS_OFS: rdata_d = {16'h0, pass_q};
         STATUS_OFS: rdata_d = {19'h0, conflict, pw_pos_q, qv_q, menu_q,
            pulse_width_selection_ok, i_alarm, pwm_w, relay_q};
         default: rdata_d = 32'h0;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_prdata <= '0;
      end else if (i_psel && !i_penable) begin
         o_prdata <= rdata_d;
      end
   end

   // ----------------------------------------
   // timebase
   // ----------------------------------------
   logic [15:0] div_q;
   logic [12:0] unit_q;
   logic ms_tick, unit_tick;
   assign ms_tick = (div_q == 16'(MS_CYCLES - 1));
   assign unit_tick = ms_tick && (unit_q == (ctrl_q.coarse_unit ?
      13'(UNIT_COARSE_MS - 1) : 13'(UNIT_FINE_MS - 1)));

   // millisecond and delay-unit enables
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_q <= '0;
         unit_q <= '0;
      end else begin
         div_q <= ms_tick ? 16'h0 : div_q + 16'h1;
         if (unit_tick) begin
            unit_q <= '0;
         end else if (ms_tick) begin
            unit_q <= unit_q + 13'h1;
         end
      end
   end

   // ----------------------------------------
   // relay switching
   // ----------------------------------------
   logic signed [16:0] v, lo, hi, h;
   logic want_on, want_off, target, differ;
   logic [15:0] dcnt_q, dly_sel;
   assign v = 17'(i_value);
   assign h = {1'b0, hysteresis_width_q};
   assign lo = (thr1_q < thr2_q) ? 17'(thr1_q) : 17'(thr2_q);
   assign hi = (thr1_q < thr2_q) ? 17'(thr2_q) : 17'(thr1_q);
   assign pulse_width_selection_ok = (ctrl_q.mode == MODE_PULSE_WIDTH_SELECTION) && i_oc_fitted;

   // border tests; between borders the state is held
   always_comb begin
      want_on = 1'b0;
      want_off = 1'b0;
      unique case (ctrl_q.mode)
         MODE_ON: begin
            want_on = v > lo + h;
            want_off = v < lo - h;
         end
         MODE_OFF: begin
            want_on = v < lo - h;
            want_off = v > lo + h;
         end
         MODE_IN: begin
            want_on = (v > lo + h) && (v < hi - h);
            want_off = (v < lo - h) || (v > hi + h);
         end
         MODE_OUT: begin
            want_on = (v < lo - h) || (v > hi + h);
            want_off = (v > lo + h) && (v < hi - h);
         end
         default: want_off = 1'b1;
      endcase
   end

   assign target = want_on ? 1'b1 : (want_off ? 1'b0 : relay_q);
   assign differ = target != relay_q;
   assign dly_sel = target ? ton_q : turn_off_delay_q;

   // delay filter; an excursion that ends early restarts the count
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dcnt_q <= '0;
      end else if (!differ || i_alarm) begin
         dcnt_q <= '0;
      end else if (unit_tick && dcnt_q != 16'hFFFF) begin
         dcnt_q <= dcnt_q + 16'h1;
      end
   end

   // relay state, with alarm override shared by both thresholds
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         relay_q <= 1'b0;
      end else if (i_alarm && ctrl_q.alarm_action != 2'h0) begin
         relay_q <= ctrl_q.alarm_action == 2'h1;
      end else if (!i_alarm && differ && dcnt_q >= dly_sel) begin
         relay_q <= target;
      end
   end

   // ----------------------------------------
   // pulse width output
   // ----------------------------------------
   logic [15:0] pcnt_q, high_q, high_d, room;
   logic [32:0] raw;
   logic [16:0] span, offs;
   logic [22:0] alarm_prod;
   logic [6:0] fill;
   logic boundary;
   assign boundary = ms_tick && (pcnt_q >= period_q - 16'h1);
   assign span = 17'(span_hi_q - span_lo_q);
   assign offs = 17'(i_value - span_lo_q);
   assign fill = (fill_q > FILL_FULL) ? FILL_FULL : fill_q;
   assign alarm_prod = period_q * fill;
   assign conflict = 17'(min_hi_q) + 17'(min_lo_q) > 17'(period_q);
   assign room = period_q - min_lo_q;

   // high time for the coming period
   always_comb begin
      if (i_alarm) begin
         raw = 33'(alarm_prod / 23'(FILL_FULL));
      end else if (i_value < span_lo_q) begin
         raw = '0;
      end else if (i_value > span_hi_q || span == 17'h0) begin
         raw = 33'(period_q);
      end else begin
         raw = (33'(offs) * 33'(period_q)) / 33'(span);
      end
      high_d = raw[15:0];
      if (high_d < min_hi_q) begin
         high_d = min_hi_q;
      end
      if (high_d > room) begin
         high_d = room;
      end
   end

   // period counter and per-period high time
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pcnt_q <= '0;
         high_q <= '0;
      end else if (boundary) begin
         pcnt_q <= '0;
         high_q <= high_d;
      end else if (ms_tick) begin
         pcnt_q <= pcnt_q + 16'h1;
      end
   end

   assign pwm_w = !conflict && (pcnt_q < high_q);
   assign out_d = pulse_width_selection_ok ? pwm_w : (relay_q && ctrl_q.mode != MODE_PULSE_WIDTH_SELECTION);

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_relay <= 1'b0;
      end else begin
         o_relay <= out_d;
      end
   end

   // ----------------------------------------
   // keypad
   // ----------------------------------------
   key_t k1_q, k2_q, k3_q, press;
   logic any_press;
   logic [16:0] idle_q;
   logic [10:0] hold_q;

   // pin synchroniser and press edges
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         k1_q <= '0;
         k2_q <= '0;
         k3_q <= '0;
      end else begin
         k1_q <= i_keys;
         k2_q <= k1_q;
         k3_q <= k2_q;
      end
   end
   assign press = k2_q & ~k3_q;
   assign any_press = |press;

   // idle and hold timers in milliseconds
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         idle_q <= '0;
         hold_q <= '0;
      end else begin
         if (any_press) begin
            idle_q <= '0;
         end else if (ms_tick && idle_q != 17'h1FFFF) begin
            idle_q <= idle_q + 17'h1;
         end
         if (!k2_q.esc || menu_q != ST_MEAS) begin
            hold_q <= '0;
         end else if (ms_tick && hold_q != 11'(MENU_HOLD_MS)) begin
            hold_q <= hold_q + 11'h1;
         end
      end
   end

   // ----------------------------------------
   // menu walker
   // ----------------------------------------
   logic [2:0] top_q, sub_q;
   logic pw_ok, held;
   assign pw_ok = {pw_dig_q[0], pw_dig_q[1], pw_dig_q[2], pw_dig_q[3]} == pass_q;
   assign held = hold_q == 11'(MENU_HOLD_MS);

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         menu_q <= ST_MEAS;
         top_q <= '0;
         sub_q <= '0;
         pw_pos_q <= '0;
      end else begin
         unique case (menu_q)
            ST_MEAS: begin
               if (held) begin
                  menu_q <= (pass_q != 16'h0) ? ST_PASS : ST_TOP;
                  top_q <= '0;
                  pw_pos_q <= '0;
               end else if (press.enter && ctrl_q.free_access && qv_q < 3'h2) begin
                  menu_q <= ST_QEDIT;
               end
            end
            ST_PASS: begin
               if (press.enter) begin
                  pw_pos_q <= pw_pos_q + 2'h1;
                  if (pw_pos_q == 2'(PW_DIGITS - 1)) begin
                     menu_q <= pw_ok ? ST_TOP : ST_ERR;
                  end
               end else if (press.esc) begin
                  menu_q <= ST_MEAS;
               end
            end
            ST_TOP: begin
               if (press.up) begin
                  top_q <= (top_q == 3'(TOP_ITEMS - 1)) ? 3'h0 : top_q + 3'h1;
               end else if (press.down) begin
                  top_q <= (top_q == 3'h0) ? 3'(TOP_ITEMS - 1) : top_q - 3'h1;
               end else if (press.enter) begin
                  menu_q <= ST_SUB;
                  sub_q <= '0;
               end else if (press.esc || idle_q >= 17'(MENU_IDLE_MS)) begin
                  menu_q <= ST_MEAS;
               end
            end
            ST_SUB: begin
               if (press.up) begin
                  sub_q <= (sub_q == 3'(SUB_ITEMS - 1)) ? 3'h0 : sub_q + 3'h1;
               end else if (press.down) begin
                  sub_q <= (sub_q == 3'h0) ? 3'(SUB_ITEMS - 1) : sub_q - 3'h1;
               end else if (press.enter) begin
                  menu_q <= ST_EDIT;
               end else if (press.esc) begin
                  menu_q <= ST_TOP;
               end else if (idle_q >= 17'(MENU_IDLE_MS)) begin
                  menu_q <= ST_MEAS;
               end
            end
            ST_EDIT: begin
               if (press.enter || press.esc) begin
                  menu_q <= ST_SUB;
               end
            end
            ST_QEDIT: begin
               if (press.enter || press.esc) begin
                  menu_q <= ST_MEAS;
               end
            end
            ST_ERR: begin
               if (idle_q >= 17'(ERR_SHOW_MS)) begin
                  menu_q <= ST_MEAS;
               end
            end
            default: menu_q <= ST_MEAS;
         endcase
      end
   end

   // password digits, one per position, stepped by up and down
   for (genvar g = 0; g < PW_DIGITS; g++) begin : g_pw
      always_ff @(posedge i_clock or negedge i_rst_n) begin
         if (!i_rst_n) begin
            pw_dig_q[g] <= '0;
         end else if (menu_q != ST_PASS) begin
            pw_dig_q[g] <= '0;
         end else if (pw_pos_q == 2'(g) && press.up) begin
            pw_dig_q[g] <= (pw_dig_q[g] == 4'h9) ? 4'h0 : pw_dig_q[g] + 4'h1;
         end else if (pw_pos_q == 2'(g) && press.down) begin
            pw_dig_q[g] <= (pw_dig_q[g] == 4'h0) ? 4'h9 : pw_dig_q[g] - 4'h1;
         end
      end
   end

   // quick view item, back to the display choice after 5 s idle
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         qv_q <= '0;
      end else if (menu_q != ST_MEAS) begin
         qv_q <= ctrl_q.display_menu_sel;
      end else if (press.up) begin
         qv_q <= (qv_q == 3'(QV_ITEMS - 1)) ? 3'h0 : qv_q + 3'h1;
      end else if (press.down) begin
         qv_q <= (qv_q == 3'h0) ? 3'(QV_ITEMS - 1) : qv_q - 3'h1;
      end else if (idle_q >= 17'(QV_TIMEOUT_MS)) begin
         qv_q <= ctrl_q.display_menu_sel;
      end
   end

   // display view; password shows only the digit under edit
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_display_menu <= '0;
      end else begin
         o_display_menu.state <= menu_q;
         o_display_menu.qv_index <= qv_q;
         o_display_menu.digit_shown <= (menu_q == ST_PASS) ? 4'h1 << pw_pos_q : 4'h0;
         o_display_menu.err <= menu_q == ST_ERR;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence long_hold_s;
      menu_q == ST_MEAS && held;
   endsequence
   sequence last_digit_s;
      menu_q == ST_PASS && press.enter && pw_pos_q == 2'(PW_DIGITS - 1);
   endsequence

   conflict_low_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      pulse_width_selection_ok && conflict |=> !o_relay) else $error("output high despite conflict");
   zero_fill_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      boundary && !i_alarm && i_value < span_lo_q && min_hi_q == 16'h0 |=> high_q == 16'h0)
      else $error("fill not zero below span");
   full_fill_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      boundary && !i_alarm && i_value > span_hi_q && min_lo_q == 16'h0
      |=> high_q == $past(period_q)) else $error("fill not full above span");
   min_high_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      boundary && !conflict |=> high_q >= $past(min_hi_q) && high_q <= $past(room))
      else $error("minimum times violated");
   alarm_fill_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      boundary && i_alarm && !conflict && min_hi_q == 16'h0 && min_lo_q == 16'h0
      |=> high_q == 16'($past(alarm_prod) / 23'(FILL_FULL))) else $error("alarm fill wrong");
   relay_delay_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      !i_alarm && !$past(i_alarm) && $changed(relay_q) |-> $past(dcnt_q) >= $past(dly_sel))
      else $error("relay changed before delay");
   inside_on_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      ctrl_q.mode == MODE_IN && v > lo + h && v < hi - h && ton_q == 16'h0 && !i_alarm
      |=> relay_q) else $error("inside zone relay not on");
   menu_entry_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      long_hold_s |=> menu_q == ST_PASS || menu_q == ST_TOP) else $error("menu not entered");
   early_entry_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      menu_q == ST_MEAS ##1 (menu_q == ST_PASS || menu_q == ST_TOP) |-> $past(held))
      else $error("menu entered without hold");
   pw_result_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      last_digit_s |=> (menu_q == ST_TOP) == $past(pw_ok) ##1 o_display_menu.err == !$past(pw_ok, 2))
      else $error("password outcome wrong");
   idle_exit_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (menu_q == ST_TOP || menu_q == ST_SUB) && idle_q >= 17'(MENU_IDLE_MS) && !any_press
      |=> menu_q == ST_MEAS) else $error("idle menu not left");
endmodule

//--- include/relay_pwm_pkg.sv
/*
 Shared constants and types of the relay and pulse output control block.
 Assumes a 20 MHz system clock and a 32-bit APB register bus.
*/
package relay_pwm_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int QV_TIMEOUT_MS = 5000;
   localparam int MENU_HOLD_MS = 2000;
   localparam int MENU_IDLE_MS = 60000;
   localparam int ERR_SHOW_MS = 1000;
   localparam int UNIT_FINE_MS = 100;
   localparam int UNIT_COARSE_MS = 6000;
   localparam int PW_DIGITS = 4;
   localparam int QV_ITEMS = 8;
   localparam int TOP_ITEMS = 8;
   localparam int SUB_ITEMS = 8;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] THR_OFS = 8'h04;
   localparam logic [7:0] HYSTERESIS_WIDTH_OFS = 8'h08;
   localparam logic [7:0] DELAY_OFS = 8'h0C;
   localparam logic [7:0] SPAN_OFS = 8'h10;
   localparam logic [7:0] PERIOD_OFS = 8'h14;
   localparam logic [7:0] MINT_OFS = 8'h18;
   localparam logic [7:0] FILL_OFS = 8'h1C;
   localparam logic [7:0] PASS_OFS = 8'h20;
   localparam logic [7:0] STATUS_OFS = 8'h24;
   localparam logic [15:0] PERIOD_RESET = 16'h03E8;
   localparam logic [6:0] FILL_FULL = 7'h64;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [2:0] {
      MODE_NOAC = 3'h0, MODE_ON = 3'h1, MODE_OFF = 3'h2,
      MODE_IN = 3'h3, MODE_OUT = 3'h4, MODE_PULSE_WIDTH_SELECTION = 3'h5
   } mode_t;
   typedef enum logic [2:0] {
      ST_MEAS = 3'b000, ST_PASS = 3'b001, ST_TOP = 3'b011, ST_SUB = 3'b010,
      ST_EDIT = 3'b110, ST_ERR = 3'b111, ST_QEDIT = 3'b101
   } menu_t;
   typedef struct packed {
      logic [21:0] rsvd;
      logic [2:0] display_menu_sel;
      logic free_access;
      logic coarse_unit;
      logic [1:0] alarm_action;
      mode_t mode;
   } ctrl_t;
   localparam ctrl_t CTRL_RESET = '0;
   typedef struct packed {
      logic up;
      logic down;
      logic enter;
      logic esc;
   } key_t;
   typedef struct packed {
      menu_t state;
      logic [2:0] qv_index;
      logic [3:0] digit_shown;
      logic err;
   } display_menu_t;
endpackage

//--- verification/relay_threshold_pwm_control_test.sv
/*
 Self-checking bench of the relay threshold, pulse output and menu block.
 Assumes zero-wait APB, ms timers scaled by MS_CYCLES and keys as pin levels.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
   $display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); end end
module relay_threshold_pwm_control_test;
   import relay_pwm_pkg::*;
   localparam int MSC = 1; // one cycle per ms, so the minute idle fits the run
   logic i_clock = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
   logic [7:0] i_paddr = '0;
   logic [31:0] i_pwdata = '0, o_prdata, rdat;
   logic o_pready, o_pslverr, rerr, i_alarm = 0, i_oc_fitted = 1, o_relay;
   logic signed [15:0] i_value = '0;
   key_t i_keys = '0;
   display_menu_t o_display_menu;
   int err_count = 0, cmp_count = 0, cyc = 0, n;
   relay_threshold_pwm_control #(.MS_CYCLES(MSC)) dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
      .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .i_value(i_value), .i_alarm(i_alarm), .i_oc_fitted(i_oc_fitted), .i_keys(i_keys),
      .o_relay(o_relay), .o_display_menu(o_display_menu));
   // ----------------------------------------
   // clock, timeout and verdict
   // ----------------------------------------
   initial begin
      forever #25 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         err_count++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ----------------------------------------
   // apb cycles, key presses, duty measure
   // ----------------------------------------
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_psel <= 1; i_penable <= 0; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
      @(posedge i_clock);
      i_penable <= 1;
      do @(posedge i_clock); while (o_pready !== 1'b1);
      rdat = o_prdata; // taken at the pready edge
      rerr = o_pslverr;
      i_psel <= 0; i_penable <= 0;
   endtask
   task automatic key(input logic [3:0] k, input int hold);
      i_keys <= key_t'(k);
      repeat (hold) @(posedge i_clock);
      i_keys <= '0;
      repeat (8) @(posedge i_clock);
   endtask
   // high cycles over exactly one 10 ms period after eight settling periods
   task automatic duty(output int cnt);
      cnt = 0;
      repeat (80) @(posedge i_clock);
      repeat (10 * MSC) begin
         @(posedge i_clock);
         if (o_relay === 1'b1) cnt++;
      end
   endtask
   task automatic setv(input logic signed [15:0] v);
      @(posedge i_clock);
      i_value <= v;
      repeat (6) @(posedge i_clock);
   endtask
   logic [3:0] seq_k [5] = '{4'h2, 4'h2, 4'h1, 4'h1, 4'h1};
   menu_t seq_s [5] = '{ST_SUB, ST_EDIT, ST_SUB, ST_TOP, ST_MEAS};
   initial begin
      repeat (3) @(posedge i_clock);
      i_rst_n <= 1;
      // reset values and unmapped place
      xfer(0, PERIOD_OFS, 0); `CHK(rdat, 32'h0000_03E8)
      xfer(0, CTRL_OFS, 0); `CHK(rdat, 32'h0000_0000)
      xfer(0, 8'h28, 0); `CHK({rerr, rdat}, 33'h1_0000_0000)
      $display("test regs done");
      // relay: thresholds in reverse order, inside then outside
      xfer(1, THR_OFS, 32'h0064_00C8); xfer(1, HYSTERESIS_WIDTH_OFS, 32'h0000_000A);
      xfer(1, CTRL_OFS, 32'h0000_0003);
      setv(150); `CHK(o_relay, 1'b1)
      setv(50); `CHK(o_relay, 1'b0)
      setv(250); `CHK(o_relay, 1'b0)
      xfer(1, CTRL_OFS, 32'h0000_0004); setv(250); `CHK(o_relay, 1'b1)
      setv(150); `CHK(o_relay, 1'b0)
      // short excursion against a 5-unit turn-on delay
      xfer(1, CTRL_OFS, 32'h0000_0003); setv(50); xfer(1, DELAY_OFS, 32'h0000_0005);
      setv(150); repeat (100) @(posedge i_clock); setv(50); `CHK(o_relay, 1'b0)
      // alarm with force-on action overrides the zone decision
      xfer(1, CTRL_OFS, 32'h0000_000B); i_alarm <= 1; setv(50); `CHK(o_relay, 1'b1)
      i_alarm <= 0;
      $display("test relay done");
      // pulse mode: 10 ms period, span 0..100
      xfer(1, DELAY_OFS, 0); xfer(1, SPAN_OFS, 32'h0064_0000); xfer(1, PERIOD_OFS, 32'h0A);
      xfer(1, FILL_OFS, 32'h1E); xfer(1, CTRL_OFS, 32'h0000_0005);
      setv(50); duty(n); `CHK(n, 5 * MSC)
      setv(-5); duty(n); `CHK(n, 0)
      setv(200); duty(n); `CHK(n, 10 * MSC)
      i_alarm <= 1; duty(n); `CHK(n, 3 * MSC)
      i_alarm <= 0; setv(10); xfer(1, MINT_OFS, 32'h0000_0004);
      duty(n); `CHK(n, 4 * MSC)
      xfer(1, MINT_OFS, 32'h0005_0006); duty(n); `CHK(n, 0)
      xfer(1, MINT_OFS, 0); setv(50); i_oc_fitted <= 0; duty(n); `CHK(n, 0)
      $display("test pulse done");
      // menu entry by long escape hold, then walk down and up
      xfer(1, CTRL_OFS, 32'h0000_0000);
      i_keys <= key_t'(4'h1); repeat (1950 * MSC) @(posedge i_clock);
      `CHK(o_display_menu.state, ST_MEAS)
      repeat (60 * MSC) @(posedge i_clock); `CHK(o_display_menu.state, ST_TOP)
      i_keys <= '0; repeat (8) @(posedge i_clock);
      for (int i = 0; i < 5; i++) begin
         key(seq_k[i], 6); `CHK(o_display_menu.state, seq_s[i])
      end
      $display("test menu done");
      // password: masked digit, wrong entry gives error then measurement
      xfer(1, PASS_OFS, 32'h0000_1000);
      key(4'h1, 2010 * MSC); `CHK(o_display_menu.state, ST_PASS)
      `CHK(o_display_menu.digit_shown, 4'h1)
      repeat (4) key(4'h2, 6);
      `CHK(o_display_menu.state, ST_ERR)
      repeat (1010 * MSC) @(posedge i_clock); `CHK(o_display_menu.state, ST_MEAS)
      $display("test password done");
      // quick view stepping, revert after idle, free-access edit
      key(4'h8, 6); `CHK(o_display_menu.qv_index, 3'h1)
      repeat (4900 * MSC) @(posedge i_clock); `CHK(o_display_menu.qv_index, 3'h1)
      repeat (120 * MSC) @(posedge i_clock); `CHK(o_display_menu.qv_index, 3'h0)
      xfer(1, CTRL_OFS, 32'h0000_0040);
      key(4'h2, 6); `CHK(o_display_menu.state, ST_QEDIT)
      key(4'h1, 6); `CHK(o_display_menu.state, ST_MEAS)
      $display("test quick view done");
      // correct password opens the menu, a minute without keys leaves it
      key(4'h1, 2010 * MSC); key(4'h8, 6);
      repeat (4) key(4'h2, 6);
      `CHK(o_display_menu.state, ST_TOP)
      repeat (59900 * MSC) @(posedge i_clock); `CHK(o_display_menu.state, ST_TOP)
      repeat (100 * MSC) @(posedge i_clock); `CHK(o_display_menu.state, ST_MEAS)
      $display("test idle exit done");
      give_verdict();
   end
endmodule
